// File: inc/talk_pkg.sv
// Constants, types and register layout for the talk button mute control.
// How it works
// - Two config bits pick main button mode: mute, talk, alternate, hybrid.
// - Push to mute: main active, muted only while button held.
// - Push to talk: main muted, active only while button held.
// - Alternate: each press toggles main; starts muted after reset.
// - Hybrid main: held press keeps main active until release; starts muted.
// - Hybrid main: brief tap toggles main and the state stays.
// - Talkback 1 push to talk or hybrid by one bit; talk only while held.
// - Talkback 1 hybrid: active while held, tap toggles, starts muted.
// - Talkback 2 push to talk or hybrid by one bit; talk only while held.
// - Talkback 2 hybrid: active while held, tap toggles, starts muted.
// - Talkback 2 enabled: audio follows button unless hot mic or copy mode.
// - Talkback 2 disabled: audio off except in hot mic or copy mode; button still drives relay if chosen.
// - Two bits pick relay mode; disabled relay never changes state.
// - Main follow relay mode: relay on exactly while main is active.
// - Button follow relay modes: relay on while chosen talkback button is active.
// - Level/level: each pot sets one headphone channel level.
// - Level/balance: left pot level, right pot balance, CCW favours left.
// - Reverse swaps pots in level/level, inverts balance in level/balance.
// - Limited setting: channel never below 40 dB under maximum.
// - Full mute: pot ends mute their channel(s) completely.
// - One bit routes preamp or compressor signal to main output.
// - On-air modes mute main while talkback 1 is active, or talkback 2 outside hot mic and copy mode; latch restored.
`default_nettype none
package talk_pkg;
  localparam int CLK_HZ       = 125_000_000;
  localparam int DEBOUNCE_MS  = 5;
  localparam int HOLD_MS      = 300;
  localparam int DB_CYC_DEF   = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int HOLD_CYC_DEF = HOLD_MS * (CLK_HZ / 1000);
  localparam int DB_W         = 20;
  localparam int HOLD_W       = 26;
  localparam int CFG_W        = 13;
  localparam int PADDR_W      = 12;

  localparam logic [11:0] ADDR_CFG    = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_HP     = 12'h008;

  localparam logic [12:0] CFG_RST  = 13'h0000;
  localparam logic [7:0]  HP_MIN   = 8'h03;
  localparam logic [7:0]  HP_FULL  = 8'hFF;
  localparam logic        HP_LIMIT = 1'h0;

  localparam logic [1:0] MAIN_PTM = 2'h0;
  localparam logic [1:0] MAIN_PTT = 2'h1;
  localparam logic [1:0] MAIN_ALT = 2'h2;
  localparam logic [1:0] MAIN_HYB = 2'h3;

  localparam logic [1:0] RLY_OFF  = 2'h0;
  localparam logic [1:0] RLY_MAIN = 2'h1;
  localparam logic [1:0] RLY_TB1  = 2'h2;
  localparam logic [1:0] RLY_TB2  = 2'h3;

  localparam logic [1:0] SYS_ONAIR  = 2'h0;
  localparam logic [1:0] SYS_HOTMIC = 2'h1;
  localparam logic [1:0] SYS_FOLLOW = 2'h2;
  localparam logic [1:0] SYS_PROD   = 2'h3;

  typedef enum logic [2:0] {
    BTN_IDLE = 3'b001,
    BTN_TAP  = 3'b010,
    BTN_HOLD = 3'b100
  } btn_state_t;

  typedef struct packed {
    logic [1:0] system_mode;
    logic       main_source_select;
    logic       headphone_min_level_select;
    logic       headphone_reverse_select;
    logic       headphone_level_balance_select;
    logic       relay_mode_bit1;
    logic       relay_mode_bit0;
    logic       talkback2_function_enable;
    logic       talkback2_button_mode;
    logic       talkback1_button_mode;
    logic       main_button_mode_bit1;
    logic       main_button_mode_bit0;
  } cfg_t;

  typedef struct packed {
    logic       main_active;
    logic       tb1_active;
    logic       tb2_active;
    logic       relay_on;
    logic       main_src_comp;
    logic [7:0] hp_left_gain;
    logic [7:0] hp_right_gain;
  } out_t;

  typedef struct packed {
    cfg_t                         cfg;
    logic [2:0]                   db;
    logic [2:0][DB_W-1:0]         db_cnt;
    btn_state_t [2:0]             bst;
    logic [2:0][HOLD_W-1:0]       hold_cnt;
    logic [2:0]                   latch;
    out_t                         out;
    logic [31:0]                  rdata;
  } ctl_t;
endpackage
`default_nettype wire

// File: src/talk_ctl.sv
// Button, relay and headphone control with APB configuration registers.
//
// The register addresses and the APB register port were chosen for this implementation.
`default_nettype none
module talk_ctl
  import talk_pkg::*;
#(
  parameter int DB_CYC   = DB_CYC_DEF,
  parameter int HOLD_CYC = HOLD_CYC_DEF
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [2:0]         btn_in,
  input  wire logic [7:0]         pot_left,
  input  wire logic [7:0]         pot_right,
  output logic                    main_active,
  output logic                    tb1_active,
  output logic                    tb2_active,
  output logic                    relay_on,
  output logic                    main_src_comp,
  output logic [7:0]              hp_left_gain,
  output logic [7:0]              hp_right_gain
);

  if (DB_CYC < 1 || DB_CYC >= (1 << DB_W)) begin : g_db_chk
    $error("DB_CYC out of range");
  end
  if (HOLD_CYC < 2 || HOLD_CYC >= (1 << HOLD_W)) begin : g_hold_chk
    $error("HOLD_CYC out of range");
  end

  ctl_t s;
  ctl_t n;

  // Button output state from mode, debounced press and latch
  function automatic logic btn_active(input logic [1:0] mode,
                                      input logic       pressed,
                                      input logic       latch);
    logic a;
    a = 1'b0;
    case (mode)
      MAIN_PTM: a = ~pressed;
      MAIN_PTT: a = pressed;
      MAIN_ALT: a = latch;
      MAIN_HYB: a = latch | pressed;
      default:  a = 1'b0;
    endcase
    return a;
  endfunction

  // Level times factor, full scale maps to full scale
  function automatic logic [7:0] hp_gain(input logic [7:0] level,
                                         input logic [7:0] factor,
                                         input logic       limit);
    logic [16:0] p;
    logic [7:0]  g;
    p = 17'(level) * 17'({1'b0, factor} + 9'h001);
    g = p[15:8];
    if (limit && g < HP_MIN) begin
      g = HP_MIN;
    end
    return g;
  endfunction

  function automatic logic [31:0] rd_word(input logic [11:0] a,
                                          input ctl_t st);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      ADDR_CFG:    w = {19'h00000, st.cfg};
      ADDR_STATUS: w = {21'h000000, st.latch, st.db, st.out.main_src_comp,
                        st.out.relay_on, st.out.tb2_active,
                        st.out.tb1_active, st.out.main_active};
      ADDR_HP:     w = {16'h0000, st.out.hp_right_gain,
                        st.out.hp_left_gain};
      default:     w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  logic       mapped;
  logic [1:0] main_mode;
  logic [1:0] relay_mode;
  logic [1:0] tb_mode [3];
  logic [2:0] hyb;
  logic [2:0] act;
  logic       onair;
  logic       tb2_talk;
  logic       main_nxt;
  logic [7:0] lvl_l;
  logic [7:0] lvl_r;
  logic [7:0] bal;
  logic [7:0] fac_l;
  logic [7:0] fac_r;
  logic       lim;

  assign mapped = paddr == ADDR_CFG || paddr == ADDR_STATUS ||
                  paddr == ADDR_HP;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = s.rdata;

  assign main_mode  = {s.cfg.main_button_mode_bit1,
                       s.cfg.main_button_mode_bit0};
  assign relay_mode = {s.cfg.relay_mode_bit1, s.cfg.relay_mode_bit0};
  assign onair = s.cfg.system_mode != SYS_PROD;

  always_comb begin
    n = s;
    tb_mode[0] = main_mode;
    tb_mode[1] = s.cfg.talkback1_button_mode ? MAIN_HYB : MAIN_PTT;
    tb_mode[2] = s.cfg.talkback2_button_mode ? MAIN_HYB : MAIN_PTT;
    if (psel && penable && pwrite && paddr == ADDR_CFG) begin
      n.cfg = cfg_t'(pwdata[CFG_W-1:0]);
    end
    if (psel && !penable) begin
      n.rdata = rd_word(paddr, s);
    end
    for (int i = 0; i < 3; i++) begin
      hyb[i] = tb_mode[i] == MAIN_HYB;
      // Debounce: input must differ for DB_CYC cycles in a row
      if (btn_in[i] != s.db[i]) begin
        if (s.db_cnt[i] == DB_W'(DB_CYC - 1)) begin
          n.db[i]     = btn_in[i];
          n.db_cnt[i] = '0;
        end else begin
          n.db_cnt[i] = s.db_cnt[i] + 1'b1;
        end
      end else begin
        n.db_cnt[i] = '0;
      end
      case (s.bst[i])
        BTN_IDLE: begin
          n.hold_cnt[i] = '0;
          if (s.db[i]) begin
            n.bst[i] = BTN_TAP;
            if (tb_mode[i] == MAIN_ALT) begin
              n.latch[i] = ~s.latch[i];
            end
          end
        end
        BTN_TAP: begin
          if (!s.db[i]) begin
            n.bst[i] = BTN_IDLE;
            if (hyb[i]) begin
              n.latch[i] = ~s.latch[i];
            end
          end else if (s.hold_cnt[i] == HOLD_W'(HOLD_CYC - 1)) begin
            n.bst[i] = BTN_HOLD;
          end else begin
            n.hold_cnt[i] = s.hold_cnt[i] + 1'b1;
          end
        end
        BTN_HOLD: begin
          if (!s.db[i]) begin
            n.bst[i] = BTN_IDLE;
          end
        end
        default: n.bst[i] = BTN_IDLE;
      endcase
      act[i] = btn_active(tb_mode[i], s.db[i], s.latch[i]);
    end

    tb2_talk = s.cfg.talkback2_function_enable && act[2] &&
               s.cfg.system_mode != SYS_HOTMIC &&
               s.cfg.system_mode != SYS_FOLLOW;
    // Latch is untouched, so main comes back when talkback ends
    main_nxt = act[0] && !(onair && (act[1] || tb2_talk));
    n.out.main_active = main_nxt;
    n.out.tb1_active  = act[1];
    case (s.cfg.system_mode)
      SYS_HOTMIC: n.out.tb2_active = 1'b1;
      SYS_FOLLOW: n.out.tb2_active = main_nxt;
      default:    n.out.tb2_active = tb2_talk;
    endcase
    case (relay_mode)
      RLY_MAIN: n.out.relay_on = main_nxt;
      RLY_TB1:  n.out.relay_on = act[1];
      RLY_TB2:  n.out.relay_on = act[2];
      default:  n.out.relay_on = s.out.relay_on;
    endcase
    n.out.main_src_comp = s.cfg.main_source_select;

    lvl_l = pot_left;
    lvl_r = pot_right;
    lim = s.cfg.headphone_min_level_select == HP_LIMIT;
    // Balance 0 is fully CCW; reverse flips the direction
    bal   = s.cfg.headphone_reverse_select ? ~pot_right : pot_right;
    fac_l = bal[7] ? {~bal[6:0], 1'b0} : HP_FULL;
    fac_r = bal[7] ? HP_FULL : {bal[6:0], 1'b0};
    if (s.cfg.headphone_level_balance_select) begin
      n.out.hp_left_gain  = hp_gain(pot_left, fac_l, lim);
      n.out.hp_right_gain = hp_gain(pot_left, fac_r, lim);
    end else begin
      lvl_l = s.cfg.headphone_reverse_select ? pot_right : pot_left;
      lvl_r = s.cfg.headphone_reverse_select ? pot_left : pot_right;
      n.out.hp_left_gain  = hp_gain(lvl_l, HP_FULL, lim);
      n.out.hp_right_gain = hp_gain(lvl_r, HP_FULL, lim);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '{cfg: cfg_t'(CFG_RST), db: 3'h0, db_cnt: '0,
             bst: {BTN_IDLE, BTN_IDLE, BTN_IDLE}, hold_cnt: '0,
             latch: 3'h0, out: '0, rdata: 32'h0000_0000};
    end else begin
      s <= n;
    end
  end

  assign main_active   = s.out.main_active;
  assign tb1_active    = s.out.tb1_active;
  assign tb2_active    = s.out.tb2_active;
  assign relay_on      = s.out.relay_on;
  assign main_src_comp = s.out.main_src_comp;
  assign hp_left_gain  = s.out.hp_left_gain;
  assign hp_right_gain = s.out.hp_right_gain;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_ptm_held_mute:
    assert property (main_mode == MAIN_PTM && s.db[0] |=> !main_active)
    else $error("main not muted while held in push to mute");
  a_ptt_idle_mute:
    assert property (main_mode == MAIN_PTT && !s.db[0] |=> !main_active)
    else $error("main active with push to talk released");
  a_alt_press_tgl:
    assert property (main_mode == MAIN_ALT && s.bst[0] == BTN_IDLE &&
                     s.db[0] |=> s.latch[0] != $past(s.latch[0]))
    else $error("alternate press did not toggle");
  a_hyb_hold_on:
    assert property (main_mode == MAIN_HYB && s.bst[0] == BTN_HOLD &&
                     s.db[0] && !onair |=> main_active)
    else $error("hybrid hold did not make main active");
  a_tb1_tap_tgl:
    assert property (s.cfg.talkback1_button_mode && s.bst[1] == BTN_TAP &&
                     !s.db[1] |=> s.latch[1] != $past(s.latch[1]) ##1
                     tb1_active == s.latch[1])
    else $error("talkback 1 tap did not toggle");
  a_onair_mute:
    assert property ($past(onair) && tb1_active |-> !main_active)
    else $error("main active during talkback on air");
  a_relay_frozen:
    assert property (relay_mode == RLY_OFF |=> $stable(relay_on))
    else $error("disabled relay changed");
  a_relay_main:
    assert property (relay_mode == RLY_MAIN |=> relay_on == main_active)
    else $error("relay differs from main");
  a_tb2_off:
    assert property (!s.cfg.talkback2_function_enable &&
                     (s.cfg.system_mode == SYS_ONAIR ||
                      s.cfg.system_mode == SYS_PROD) |=> !tb2_active)
    else $error("disabled talkback 2 audio active");
  a_hp_floor:
    assert property (s.cfg.headphone_min_level_select == HP_LIMIT |=>
                     hp_left_gain >= HP_MIN && hp_right_gain >= HP_MIN)
    else $error("headphone below floor");

endmodule
`default_nettype wire

// File: dv/panel_model.sv
// Pushbutton panel with contact bounce, plus a relay flip counter.
`default_nettype none
module panel_model (
  input  wire logic       sys_clk,
  input  wire logic [2:0] press,
  input  wire logic       relay_on,
  output logic [2:0]      btn_in,
  output logic [7:0]      relay_flips
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] p1_ff    = 3'h0;
  logic [2:0] p2_ff    = 3'h0;
  logic       relay_ff = 1'b0;
  logic [7:0] flips_ff = 8'h00;
  always_ff @(posedge sys_clk) begin
    p1_ff    <= press;
    p2_ff    <= p1_ff;
    relay_ff <= relay_on;
    if (relay_ff !== relay_on) begin
      flips_ff <= flips_ff + 8'h01;
    end
  end
  // One cycle back at the old level after each contact change
  assign btn_in = (press & ~(p1_ff ^ p2_ff)) | (p2_ff & (p1_ff ^ p2_ff));
  assign relay_flips = flips_ff;
endmodule
`default_nettype wire

// File: dv/talk_ctl_tb.sv
// Self-checking bench for the talk button mute control.
`default_nettype none
module talk_ctl_tb;
  import talk_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DB = 4;
  localparam int HOLD = 20;
  localparam int SETTLE = DB + 6;
  localparam logic [3:0] IDLE = 4'b0001;
  localparam logic [3:0] HELD = 4'b1110;
  // Second press: alternate toggles back off, hybrid latch still on
  localparam logic [3:0] HLD2 = 4'b1010;
  localparam logic [3:0] AFT1 = 4'b1101;
  localparam logic [3:0] AFT2 = 4'b0001;
  logic               sys_clk = 1'b0;
  logic               rst = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = '0;
  logic [31:0]        pwdata = '0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [2:0]         press = 3'h0;
  logic [2:0]         btn_in;
  logic [7:0]         pot_left = 8'h00;
  logic [7:0]         pot_right = 8'h00;
  logic               main_active;
  logic               tb1_active;
  logic               tb2_active;
  logic               relay_on;
  logic               main_src_comp;
  logic [7:0]         hp_left_gain;
  logic [7:0]         hp_right_gain;
  logic [7:0]         relay_flips;
  logic [7:0]         flips0;
  logic [31:0]        rd;
  logic               er;
  int                 err_total = 0;
  int                 n_compared = 0;
  int                 cycles = 0;

  talk_ctl #(.DB_CYC(DB), .HOLD_CYC(HOLD)) dut (.sys_clk(sys_clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .btn_in(btn_in), .pot_left(pot_left),
    .pot_right(pot_right), .main_active(main_active),
    .tb1_active(tb1_active), .tb2_active(tb2_active), .relay_on(relay_on),
    .main_src_comp(main_src_comp), .hp_left_gain(hp_left_gain),
    .hp_right_gain(hp_right_gain));
  panel_model panel (.sys_clk(sys_clk), .press(press), .relay_on(relay_on),
    .btn_in(btn_in), .relay_flips(relay_flips));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    chk_reg({24'h0, got}, {24'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_cfg(input logic [12:0] v);
    apb(1'b1, ADDR_CFG, {19'h0, v});
    apb(1'b0, ADDR_CFG, 32'h0);
    chk_reg(rd, {19'h0, v});
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk_pin({7'h0, main_active}, 8'h00);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask

  function automatic logic [7:0] obs();
    return {4'h0, relay_on, tb2_active, tb1_active, main_active};
  endfunction

  task automatic tap(input int b, input int n, input logic [7:0] eh,
                     input logic [7:0] ea);
    press[b] <= 1'b1;
    cyc(n);
    chk_pin(obs(), eh);
    press[b] <= 1'b0;
    cyc(SETTLE);
    chk_pin(obs(), ea);
  endtask

  task automatic hp_case(input logic [12:0] v, input logic [7:0] pl,
                         input logic [7:0] pr, input logic [1:0] z);
    set_cfg(v);
    pot_left <= pl;
    pot_right <= pr;
    cyc(3);
    chk_pin({6'h0, hp_left_gain == 8'h00, hp_right_gain == 8'h00},
            {6'h0, z});
  endtask

  initial begin
    do_reset();
    apb(1'b0, ADDR_CFG, 32'h0);
    chk_reg(rd, {19'h0, CFG_RST});
    apb(1'b0, 12'h00C, 32'h0);
    chk_reg({er, rd[30:0]}, 32'h80000000);
    for (int m = 0; m < 4; m++) begin
      do_reset();
      set_cfg(13'h1800 | 13'(m));
      cyc(SETTLE);
      chk_pin(obs(), {7'h0, IDLE[m]});
      tap(0, SETTLE, {7'h0, HELD[m]}, {7'h0, AFT1[m]});
      tap(0, SETTLE, {7'h0, HLD2[m]}, {7'h0, AFT2[m]});
    end
    tap(0, HOLD + SETTLE, 8'h01, 8'h00);
    do_reset();
    set_cfg(13'h0054);
    cyc(SETTLE);
    tap(1, SETTLE, 8'h0A, 8'h0A);
    tap(1, SETTLE, 8'h0A, 8'h01);
    set_cfg(13'h1861);
    tap(2, SETTLE, 8'h08, 8'h00);
    tap(1, SETTLE, 8'h02, 8'h00);
    set_cfg(13'h1879);
    tap(2, SETTLE, 8'h0C, 8'h0C);
    tap(2, HOLD + SETTLE, 8'h0C, 8'h0C);
    set_cfg(13'h1871);
    tap(2, SETTLE, 8'h0C, 8'h00);
    set_cfg(13'h1821);
    tap(0, SETTLE, 8'h09, 8'h00);
    set_cfg(13'h1801);
    flips0 = relay_flips;
    tap(0, SETTLE, 8'h01, 8'h00);
    chk_pin(relay_flips, flips0);
    set_cfg(13'h1C01);
    cyc(3);
    chk_pin({7'h0, main_src_comp}, 8'h01);
    hp_case(13'h0000, 8'h00, 8'h00, 2'b00);
    chk_pin({7'h0, hp_left_gain >= HP_MIN}, 8'h01);
    hp_case(13'h0200, 8'h00, 8'hFF, 2'b10);
    hp_case(13'h0300, 8'h00, 8'hFF, 2'b01);
    hp_case(13'h0280, 8'h00, 8'h80, 2'b11);
    hp_case(13'h0280, 8'hFF, 8'h00, 2'b01);
    hp_case(13'h0380, 8'hFF, 8'h00, 2'b10);
    complete_run();
  end
endmodule
`default_nettype wire
